// >>> smspi_regs.vh
// Constants of the serial memory SPI front end
`ifndef SMSPI_REGS_VH
`define SMSPI_REGS_VH
`define SMSPI_CLK_MHZ        25
`define SMSPI_RECALL_US      50
`define SMSPI_RECALL_CYC     ((`SMSPI_RECALL_US) * (`SMSPI_CLK_MHZ))
`define SMSPI_CNT_W          11
`define SMSPI_BYTE_W         8
`define SMSPI_FIFO_DEPTH     8
`define SMSPI_OP_W           8
`define SMSPI_BIT_MSB        3'h7
`endif

// >>> smspi_fifo.v
// Parameterised valid/ready FIFO for the serial memory front end
`timescale 1ns/1ps
`default_nettype none
module smspi_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_sys_i,
  input  wire             rstn_i,
  input  wire             ce_i,
  input  wire             flush_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign in_ready_o  = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr];
  assign push        = ce_i & in_valid_i & in_ready_o;
  assign pop         = ce_i & out_valid_o & out_ready_i;

  always @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else if (ce_i) begin
      if (flush_i) begin
        wr_ptr <= {AW{1'b0}};
        rd_ptr <= {AW{1'b0}};
        count  <= {(AW+1){1'b0}};
      end else begin
        if (push) begin
          wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
        end
        if (pop) begin
          rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
        end
        if (push && !pop) begin
          count <= count + {{AW{1'b0}}, 1'b1};
        end else if (pop && !push) begin
          count <= count - {{AW{1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // smspi_fifo
`default_nettype wire

// >>> smspi_front_end.v
// Slave serial port front end of a nonvolatile serial SRAM
`timescale 1ns/1ps
`default_nettype none
`include "smspi_regs.vh"
module smspi_front_end (
  input  wire       clk_sys_i,
  input  wire       rstn_i,
  input  wire       ce_i,
  input  wire       cs_n_i,
  input  wire       sck_i,
  input  wire       si_i,
  input  wire       hold_n_i,
  output wire       so_o,
  output wire       so_oe_n_o,
  output reg  [7:0] rx_data_o,
  output wire       rx_valid_o,
  input  wire       rx_ready_i,
  output reg        rx_first_o,
  output reg        rx_overrun_o,
  input  wire [7:0] tx_data_i,
  input  wire       tx_load_i,
  output reg        tx_taken_o,
  output reg        selected_o,
  output reg        frame_end_o,
  output reg        paused_o,
  input  wire       recall_start_i,
  output reg        recall_busy_o,
  output reg        recall_done_o
);
  localparam ST_IDLE   = 3'b001;
  localparam ST_ACTIVE = 3'b010;
  localparam ST_HOLD   = 3'b100;

  reg  [1:0] cs_sync;
  reg  [1:0] sck_sync;
  reg  [1:0] si_sync;
  reg  [1:0] hold_sync;
  reg        sck_q;
  reg        cs_q;
  reg        armed;
  reg  [2:0] state;
  reg  [2:0] next_state;
  reg  [2:0] bit_cnt;
  reg  [7:0] rx_shift;
  reg  [7:0] tx_shift;
  reg        tx_pending;
  reg  [7:0] tx_hold_reg;
  reg        so_bit;
  reg        first_byte;
  reg        push;
  reg [`SMSPI_CNT_W-1:0] recall_cnt;
  wire       cs_n;
  wire       sck;
  wire       si;
  wire       hold_n;
  wire       sck_rise;
  wire       sck_fall;
  wire       cs_fall;
  wire       cs_rise;
  wire       fifo_in_ready;
  wire [31:0] recall_load;

  // Two-stage synchronisers for every pin
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      // Starts low so a select held low at power-up never looks like a fall
      cs_sync   <= 2'h0;
      sck_sync  <= 2'h0;
      si_sync   <= 2'h0;
      hold_sync <= 2'h3;
    end else if (ce_i) begin
      cs_sync   <= {cs_sync[0], cs_n_i};
      sck_sync  <= {sck_sync[0], sck_i};
      si_sync   <= {si_sync[0], si_i};
      hold_sync <= {hold_sync[0], hold_n_i};
    end
  end

  assign cs_n     = cs_sync[1];
  assign sck      = sck_sync[1];
  assign si       = si_sync[1];
  assign hold_n   = hold_sync[1];
  assign sck_rise = sck & ~sck_q;
  assign sck_fall = ~sck & sck_q;
  assign cs_fall  = ~cs_n & cs_q;
  assign cs_rise  = cs_n & ~cs_q;

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sck_q <= 1'b0;
      cs_q  <= 1'b0;
    end else if (ce_i) begin
      sck_q <= sck;
      cs_q  <= cs_n;
    end
  end

  // Frame and pause control
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cs_fall) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (cs_n) begin
          next_state = ST_IDLE;
        end else if (!hold_n && (!sck || sck_fall)) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cs_n) begin
          next_state = ST_IDLE;
        end else if (hold_n && (!sck || sck_fall)) begin
          next_state = ST_ACTIVE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
      armed <= 1'b0;
    end else if (ce_i) begin
      state <= next_state;
      armed <= 1'b1;
    end
  end

  // Receive and transmit shifters, most significant bit first
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bit_cnt      <= 3'h0;
      rx_shift     <= 8'h00;
      tx_shift     <= 8'hFF;
      tx_pending   <= 1'b0;
      tx_hold_reg  <= 8'hFF;
      so_bit       <= 1'b1;
      first_byte   <= 1'b1;
      push         <= 1'b0;
      rx_data_o    <= 8'h00;
      rx_first_o   <= 1'b0;
      rx_overrun_o <= 1'b0;
      tx_taken_o   <= 1'b0;
      selected_o   <= 1'b0;
      frame_end_o  <= 1'b0;
      paused_o     <= 1'b0;
    end else if (ce_i) begin
      push        <= 1'b0;
      tx_taken_o  <= 1'b0;
      frame_end_o <= armed & (state != ST_IDLE) & cs_rise;
      selected_o  <= (state != ST_IDLE);
      paused_o    <= (state == ST_HOLD);
      if (tx_load_i) begin
        tx_hold_reg <= tx_data_i;
        tx_pending  <= 1'b1;
      end
      if (push && fifo_in_ready) begin
        rx_overrun_o <= 1'b0;
      end
      if (state == ST_IDLE) begin
        bit_cnt    <= 3'h0;
        first_byte <= 1'b1;
        if (cs_fall) begin
          rx_overrun_o <= 1'b0;
        end
      end else if (state == ST_ACTIVE && !cs_n) begin
        if (sck_rise) begin
          rx_shift <= {rx_shift[6:0], si};
          bit_cnt  <= bit_cnt + 3'h1;
          if (bit_cnt == `SMSPI_BIT_MSB) begin
            rx_data_o  <= {rx_shift[6:0], si};
            rx_first_o <= first_byte;
            first_byte <= 1'b0;
            push       <= 1'b1;
            if (!fifo_in_ready) begin
              rx_overrun_o <= 1'b1;
            end
          end
        end
        if (sck_fall) begin
          if (bit_cnt == 3'h0) begin
            so_bit     <= tx_pending ? tx_hold_reg[7] : 1'b1;
            tx_shift   <= tx_pending ? {tx_hold_reg[6:0], 1'b1} : 8'hFF;
            tx_pending <= tx_load_i;
            tx_taken_o <= tx_pending;
          end else begin
            so_bit   <= tx_shift[7];
            tx_shift <= {tx_shift[6:0], 1'b1};
          end
        end
      end
    end
  end

  // Output floats when deselected or held, follows hold at once
  assign so_o      = so_bit;
  assign so_oe_n_o = cs_n_i | ~hold_n_i | (state == ST_IDLE);

  smspi_fifo #(
    .WIDTH (`SMSPI_BYTE_W),
    .DEPTH (`SMSPI_FIFO_DEPTH),
    .AW    (3)
  ) u_rx_fifo (
    .clk_sys_i   (clk_sys_i),
    .rstn_i      (rstn_i),
    .ce_i        (ce_i),
    .flush_i     (1'b0),
    .in_data_i   (rx_data_o),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i)
  );

  // Software recall timer
  assign recall_load = `SMSPI_RECALL_CYC - 2;

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      recall_cnt    <= {`SMSPI_CNT_W{1'b0}};
      recall_busy_o <= 1'b0;
      recall_done_o <= 1'b0;
    end else if (ce_i) begin
      recall_done_o <= 1'b0;
      if (recall_busy_o) begin
        if (recall_cnt == {`SMSPI_CNT_W{1'b0}}) begin
          recall_busy_o <= 1'b0;
          recall_done_o <= 1'b1;
        end else begin
          recall_cnt <= recall_cnt - {{(`SMSPI_CNT_W-1){1'b0}}, 1'b1};
        end
      end else if (recall_start_i) begin
        recall_busy_o <= 1'b1;
        recall_cnt    <= recall_load[`SMSPI_CNT_W-1:0];
      end
    end
  end
endmodule // smspi_front_end
`default_nettype wire

// >>> smspi_front_end_asserts.sv
// Port checks of the serial memory front end
`timescale 1ns/1ps
`default_nettype none
module smspi_chk (
  input wire logic       clk_sys_i,
  input wire logic       rstn_i,
  input wire logic       cs_n_i,
  input wire logic       sck_i,
  input wire logic       hold_n_i,
  input wire logic       so_o,
  input wire logic       so_oe_n_o,
  input wire logic [7:0] rx_data_o,
  input wire logic       selected_o,
  input wire logic       frame_end_o,
  input wire logic       paused_o,
  input wire logic       recall_busy_o,
  input wire logic       recall_done_o
);
  logic [11:0] busy_cnt;
  always_ff @(posedge clk_sys_i or negedge rstn_i)
    if (!rstn_i)
      busy_cnt <= 12'h000;
    else
      busy_cnt <= recall_busy_o ? busy_cnt + 12'h001 : 12'h000;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);
  property p_desel_float; cs_n_i |-> so_oe_n_o; endproperty
  a_desel_float: assert property (p_desel_float) else $error("so driven");
  property p_hold_float; !hold_n_i |-> so_oe_n_o; endproperty
  a_hold_float: assert property (p_hold_float) else $error("so driven in hold");
  property p_desel; cs_n_i [*6] |-> !selected_o; endproperty
  a_desel: assert property (p_desel) else $error("still selected");
  property p_sel; !cs_n_i [*6] |-> selected_o; endproperty
  a_sel: assert property (p_sel) else $error("not selected");
  property p_pause_keep; paused_o && $past(paused_o) |-> $stable(rx_data_o); endproperty
  a_pause_keep: assert property (p_pause_keep) else $error("byte in pause");
  property p_idle_keep; cs_n_i && !selected_o |=> $stable(rx_data_o); endproperty
  a_idle_keep: assert property (p_idle_keep) else $error("byte unselected");
  property p_end; $rose(cs_n_i) && selected_o |-> ##[1:6] frame_end_o; endproperty
  a_end: assert property (p_end) else $error("no frame end");
  property p_so_fall; selected_o && $changed(so_o) |-> !sck_i; endproperty
  a_so_fall: assert property (p_so_fall) else $error("so moved, clock high");
  property p_recall; recall_done_o |-> busy_cnt >= 12'h4DF && busy_cnt <= 12'h4E3; endproperty
  a_recall: assert property (p_recall) else $error("recall length");
  property p_recall_max; busy_cnt <= 12'h4E3; endproperty
  a_recall_max: assert property (p_recall_max) else $error("recall too long");
endmodule // smspi_chk
bind smspi_front_end smspi_chk u_chk (.clk_sys_i, .rstn_i, .cs_n_i, .sck_i, .hold_n_i,
  .so_o, .so_oe_n_o, .rx_data_o, .selected_o, .frame_end_o, .paused_o, .recall_busy_o,
  .recall_done_o);
`default_nettype wire

// >>> smspi_spi_master.sv
// Behavioural SPI master for the serial memory front end
`timescale 1ns/1ps
`default_nettype none
module smspi_spi_master (
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o,
  output logic      hold_n_o,
  input  wire logic so_i
);
  localparam time HALF = 160ns;
  logic idle = 1'b0;
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
    hold_n_o = 1'b1;
  end
  task automatic start(input logic mode3);
    idle = mode3;
    sck_o = mode3;
    #HALF cs_n_o = 1'b0;
    #HALF;
  endtask
  task automatic stop();
    sck_o = idle;
    #HALF cs_n_o = 1'b1;
    #HALF;
  endtask
  // Clock and data toggle while paused, ending at the starting levels
  task automatic pause();
    hold_n_o = 1'b0;
    repeat (4) begin
      #HALF sck_o = ~sck_o;
      si_o = ~si_o;
    end
    #HALF hold_n_o = 1'b1;
  endtask
  task automatic xbyte(input logic [7:0] d, input int at, input logic hi,
                       output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      sck_o = 1'b0;
      si_o = d[i];
      if (i == at && !hi)
        pause();
      #HALF sck_o = 1'b1;
      if (i == at && hi)
        pause();
      #HALF r[i] = so_i;
    end
  endtask
endmodule // smspi_spi_master
`default_nettype wire

// >>> smspi_front_end_test.sv
// Self-checking bench of the serial memory front end
`timescale 1ns/1ps
`default_nettype none
module smspi_front_end_test;
  logic       clk_sys_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic       rx_ready_i = 1'b1;
  logic       tx_load_i = 1'b0;
  logic       recall_start_i = 1'b0;
  logic [7:0] tx_data_i = 8'h00;
  logic [7:0] r;
  int         miscompares = 0;
  int         checks = 0;
  int         n;
  int         taken_seen = 0;
  wire        cs_n, sck, si, hold_n, so_o, so_oe_n_o, rx_valid_o, rx_first_o, rx_overrun_o;
  wire        tx_taken_o, selected_o, frame_end_o, paused_o, recall_busy_o, recall_done_o;
  wire [7:0]  rx_data_o;
  wire        so_w = so_oe_n_o ? ~so_o : so_o;
  always #20 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
    if (tx_taken_o === 1'b1)
      taken_seen++;
  smspi_front_end dut (.clk_sys_i, .rstn_i, .ce_i(1'b1), .cs_n_i(cs_n), .sck_i(sck),
    .si_i(si), .hold_n_i(hold_n), .so_o, .so_oe_n_o, .rx_data_o, .rx_valid_o, .rx_ready_i,
    .rx_first_o, .rx_overrun_o, .tx_data_i, .tx_load_i, .tx_taken_o, .selected_o,
    .frame_end_o, .paused_o, .recall_start_i, .recall_busy_o, .recall_done_o);
  smspi_spi_master m (.cs_n_o(cs_n), .sck_o(sck), .si_o(si), .hold_n_o(hold_n), .so_i(so_w));
  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic t_mode3();
    m.xbyte(8'hFF, 9, 1'b0, r);
    m.stop();
    chk("oe", so_oe_n_o, 1'b1);
    m.start(1'b1);
    m.xbyte(8'hC3, 9, 1'b0, r);
    tick(2);
    chk("mode3 byte", rx_data_o, 8'hC3);
    m.stop();
  endtask
  task automatic t_read();
    m.start(1'b0);
    tx_data_i = 8'h96;
    tx_load_i = 1'b1;
    tick(1);
    tx_load_i = 1'b0;
    m.xbyte(8'h03, 9, 1'b0, r);
    tick(2);
    chk("first", rx_first_o, 1'b1);
    m.xbyte(8'h5A, 9, 1'b0, r);
    tick(2);
    chk("data", rx_data_o, 8'h5A);
    chk("not first", rx_first_o, 1'b0);
    chk("so byte", r, 8'h96);
    chk("taken", taken_seen, 1);
    chk("sel", selected_o, 1'b1);
    m.stop();
    tick(6);
    chk("desel", selected_o, 1'b0);
  endtask
  task automatic t_hold();
    for (int h = 0; h < 2; h++) begin
      m.start(1'b0);
      fork
        m.xbyte(8'hB4, 3, h[0], r);
        begin
          for (n = 0; n < 300 && hold_n === 1'b1; n++)
            tick(1);
          chk("hold seen", hold_n, 1'b0);
          tick(1);
          if (h == 1)
            chk("wait fall", paused_o, 1'b0);
          tick(11);
          chk("paused", paused_o, 1'b1);
        end
      join
      tick(2);
      chk("held byte", rx_data_o, 8'hB4);
      chk("drive", so_oe_n_o, 1'b0);
      m.stop();
    end
  endtask
  task automatic t_fifo();
    rx_ready_i = 1'b0;
    m.start(1'b0);
    for (int i = 0; i < 9; i++)
      m.xbyte(8'h10 + i[7:0], 9, 1'b0, r);
    tick(2);
    chk("overrun", rx_overrun_o, 1'b1);
    m.stop();
    for (n = 0; n < 20 && rx_valid_o === 1'b1; n++) begin
      rx_ready_i = 1'b1;
      tick(1);
      rx_ready_i = 1'b0;
      tick(1);
    end
    chk("depth", n, 8);
  endtask
  task automatic t_recall();
    recall_start_i = 1'b1;
    tick(1);
    recall_start_i = 1'b0;
    for (n = 0; n < 1400 && recall_done_o !== 1'b1; n++)
      tick(1);
    chk("recall cycles", n, 1249);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    #1 rstn_i = 1'b1;
    tick(3);
    t_mode3();
    t_read();
    t_hold();
    t_fifo();
    t_recall();
    close_out();
  end
endmodule // smspi_front_end_test
`default_nettype wire
